//--- rtl/acpc_pkg.sv
package acpc_pkg;

  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SUB_PER_DEG = 8;
  localparam int TICKS_PER_HALF = 180 * SUB_PER_DEG;
  localparam logic [20:0] TICKS_PER_HALF_W = 21'(TICKS_PER_HALF);
  localparam logic [19:0] HALF_PER_INIT = 20'h6_5B9B;
  localparam logic [19:0] HALF_PER_MAX = 20'hF_FFFF;

  // ----------------------------------------------------------------
  // hold time and pulse widths
  // ----------------------------------------------------------------
  localparam int HOLD_60_MS = 34;
  localparam int HOLD_50_MS = 40;
  // rounded up in sub-degree ticks; the 60 Hz figure covers the 50 Hz one too
  localparam int HOLD_TICKS_60 = (HOLD_60_MS * 120 * TICKS_PER_HALF + 999) / 1000;
  localparam int HOLD_TICKS_50 = (HOLD_50_MS * 100 * TICKS_PER_HALF + 999) / 1000;
  localparam int HOLD_TICKS = (HOLD_TICKS_60 > HOLD_TICKS_50) ? HOLD_TICKS_60 : HOLD_TICKS_50;
  localparam logic [12:0] HOLD_TICKS_W = 13'(HOLD_TICKS);
  localparam int NARROW_60_US = 33;
  localparam int NARROW_50_US = 39;
  localparam int NARROW_TICKS = (NARROW_60_US * 120 * TICKS_PER_HALF + 999_999) / 1_000_000;
  localparam logic [15:0] NARROW_TICKS_W = 16'(NARROW_TICKS);
  localparam int WIDE_NS = 1_000_000;
  localparam int WIDE_CYCLES = WIDE_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // conduction angles, levels one to ten, in degrees
  // ----------------------------------------------------------------
  localparam int NUM_LEVELS = 10;
  localparam logic [9:0][7:0] COND_ANGLE = {
    8'h95, 8'h89, 8'h7F, 8'h77, 8'h70, 8'h6B, 8'h64, 8'h5D, 8'h56, 8'h4E
  };

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic run;
    logic off;
    logic pulse;
  } acpc_cmd_type;

  typedef enum logic [1:0] {
    FS_WAIT = 2'b01,
    FS_PULSE = 2'b10
  } acpc_fire_type;

endpackage

//--- rtl/acpc_top.sv
`timescale 1ns/100ps
// Function
// [RULE_01] a level line held low past the hold time selects its power level
// [RULE_02] the switch must hold each input low past the hold time to be seen
// [RULE_03] selected line drives its indicator until another line gets selected
// [RULE_04] after reset no level is selected and all ten lines are inputs
// [RULE_05] qualified run enables firing at the selected angle; ignored with no level
// [RULE_06] a new level while firing changes the angle at once
// [RULE_07] qualified off stops firing and keeps the selected level
// [RULE_08] run after off fires again at the kept level
// [RULE_09] holding pulse low fires; release stops unless run enabled firing
// [RULE_10] pulse ignored with no level or when run already enabled firing
// [RULE_11] one low firing pulse each sync half-cycle at the level's phase delay
// [RULE_12] levels one to ten conduct 78 86 93 100 107 112 119 127 137 149 degrees
// [RULE_13] firing pulse width is a build option: narrow about 33 us or wide 1.0 ms
// [RULE_14] all timing comes from a loop that tracks the 40 to 70 Hz sync input; the wide firing pulse width counts CORE_CLK_I cycles instead
// [RULE_15] each input is qualified by a sync-locked counter restarted on release
// [RULE_16] when several lines qualify together only the lowest-numbered is taken
module acpc_top
  import acpc_pkg::*;
#(
  parameter bit WIDE_PULSE = 1'b0,
  parameter int WIDE_CYC = WIDE_CYCLES
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic SYNC_I,
  input wire logic [9:0] PL_IN_N_I,
  output logic [9:0] PL_OUT_N_O,
  output logic [9:0] PL_OE_O,
  input wire logic RUN_N_I,
  input wire logic OFF_N_I,
  input wire logic PULSE_N_I,
  output logic TRIAC_FIRE_OUT_N_O
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] fire_delay(input logic [9:0] sel);
    logic [10:0] d;
    d = '0;
    for (int k = 0; k < NUM_LEVELS; k++) begin
      if (sel[k]) begin
        d = 11'((180 - int'(COND_ANGLE[k])) * SUB_PER_DEG);
      end
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // sync tracking loop
  // ----------------------------------------------------------------
  logic sync_d_r;
  logic sync_edge;
  logic [19:0] per_cnt_r;
  logic [19:0] half_per_r;
  logic [20:0] acc_r;
  logic [20:0] acc_sum;
  logic tick;
  logic [10:0] phase_r;

  assign sync_edge = SYNC_I ^ sync_d_r;
  assign acc_sum = acc_r + TICKS_PER_HALF_W;
  assign tick = (acc_sum >= {1'b0, half_per_r});

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      // start from the pin level so that leaving reset shows no false sync edge
      sync_d_r <= SYNC_I;
      per_cnt_r <= '0;
      half_per_r <= HALF_PER_INIT;
    end else begin
      sync_d_r <= SYNC_I;
      if (sync_edge) begin
        per_cnt_r <= '0;
        // a stalled count means sync was lost; keep the last good period
        if (per_cnt_r != HALF_PER_MAX && per_cnt_r != '0) begin
          half_per_r <= per_cnt_r + 20'h0_0001; // RULE_14
        end
      end else if (per_cnt_r != HALF_PER_MAX) begin
        per_cnt_r <= per_cnt_r + 20'h0_0001;
      end
    end
  end

  // numeric oscillator: TICKS_PER_HALF ticks per measured half-cycle
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      acc_r <= '0;
      phase_r <= '0;
    end else if (sync_edge) begin
      acc_r <= '0; // RULE_14
      phase_r <= '0;
    end else begin
      acc_r <= tick ? (acc_sum - {1'b0, half_per_r}) : acc_sum;
      if (tick && phase_r != 11'(TICKS_PER_HALF - 1)) begin
        phase_r <= phase_r + 11'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // input qualification
  // ----------------------------------------------------------------
  logic [9:0] sel_r;
  logic [12:0] qcnt_r [13];
  logic [12:0] low_n;
  logic [12:0] qual;
  logic [12:0] qevt;
  acpc_cmd_type cmd_lvl;
  acpc_cmd_type cmd_evt;

  // the selected line reads back its own low drive, so it is masked
  assign low_n = {PULSE_N_I, OFF_N_I, RUN_N_I, PL_IN_N_I | sel_r};

  always_comb begin
    for (int i = 0; i < 13; i++) begin
      qual[i] = (qcnt_r[i] == HOLD_TICKS_W);
      qevt[i] = (qcnt_r[i] == HOLD_TICKS_W - 13'h0001) && tick && !low_n[i];
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    for (int i = 0; i < 13; i++) begin
      if (RESET_I || low_n[i]) begin
        qcnt_r[i] <= '0; // RULE_15
      end else if (tick && !qual[i]) begin
        qcnt_r[i] <= qcnt_r[i] + 13'h0001; // RULE_01 RULE_02
      end
    end
  end

  assign cmd_evt = '{run: qevt[10], off: qevt[11], pulse: qevt[12]};
  assign cmd_lvl = '{run: qual[10], off: qual[11], pulse: qual[12] && !low_n[12]};

  // ----------------------------------------------------------------
  // level selection and indicators
  // ----------------------------------------------------------------
  logic [9:0] pl_evt;
  logic [9:0] pl_pick;

  assign pl_evt = qevt[9:0];
  assign pl_pick = pl_evt & (~pl_evt + 10'h001); // RULE_16

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      sel_r <= '0; // RULE_04
    end else if (pl_evt != '0) begin
      sel_r <= pl_pick; // RULE_01 RULE_03
    end
  end

  assign PL_OE_O = sel_r; // RULE_03
  assign PL_OUT_N_O = ~sel_r;

  // ----------------------------------------------------------------
  // run / off / pulse control
  // ----------------------------------------------------------------
  logic run_en_r;
  logic fire_en;

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      run_en_r <= 1'b0;
    end else if (cmd_evt.off) begin
      run_en_r <= 1'b0; // RULE_07
    end else if (cmd_evt.run && sel_r != '0) begin
      run_en_r <= 1'b1; // RULE_05 RULE_08
    end
  end

  // pulse only counts while no run enable exists and a level is chosen
  assign fire_en = run_en_r || (cmd_lvl.pulse && sel_r != '0); // RULE_09 RULE_10

  // ----------------------------------------------------------------
  // firing pulse
  // ----------------------------------------------------------------
  acpc_fire_type fs_r;
  logic fire_n_r;
  logic [15:0] wcnt_r;
  logic hit;
  logic fired_r;
  logic wstep;
  logic [15:0] wlen;

  // angle follows sel_r live, so a new level applies from the next match
  assign hit = fire_en && tick && !fired_r
    && (phase_r == fire_delay(sel_r)); // RULE_06 RULE_11 RULE_12
  assign wstep = WIDE_PULSE ? 1'b1 : tick;
  assign wlen = WIDE_PULSE ? 16'(WIDE_CYC) : NARROW_TICKS_W; // RULE_13

  // a move to a later angle after this half-cycle fired must not fire it twice
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I || sync_edge) begin
      fired_r <= 1'b0;
    end else if (hit) begin
      fired_r <= 1'b1; // RULE_11
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      fs_r <= FS_WAIT;
      fire_n_r <= 1'b1;
      wcnt_r <= '0;
    end else begin
      case (fs_r)
        FS_WAIT: begin
          if (hit) begin
            fs_r <= FS_PULSE;
            fire_n_r <= 1'b0; // RULE_11
            wcnt_r <= wlen;
          end
        end
        FS_PULSE: begin
          // width runs to its end even if firing is disabled meanwhile
          if (wstep) begin
            if (wcnt_r == 16'h0001) begin
              fs_r <= FS_WAIT;
              fire_n_r <= 1'b1;
            end
            wcnt_r <= wcnt_r - 16'h0001;
          end
        end
        default: begin
          fs_r <= FS_WAIT;
          fire_n_r <= 1'b1;
        end
      endcase
    end
  end

  assign TRIAC_FIRE_OUT_N_O = fire_n_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_RESET_CLEAR: assert property (@(posedge CORE_CLK_I) // RULE_04
    RESET_I |=> (sel_r == '0 && PL_OE_O == '0 && !run_en_r))
    else $error("selection or run enable not cleared by reset");

  AST_ONE_LEVEL: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RULE_16
    $onehot0(sel_r))
    else $error("more than one level selected");

  AST_SEL_CAUSE: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RULE_03
    !$stable(sel_r) |-> ($past(pl_evt) != '0))
    else $error("selection changed without a qualified level line");

  AST_SEL_LOWEST: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RULE_01
    (pl_evt != '0) |=> ($onehot(sel_r) && (sel_r & $past(pl_evt)) != '0
      && ((sel_r - 10'h001) & $past(pl_evt)) == '0))
    else $error("qualified level line not taken as the lowest one");

  AST_RUN_NEEDS_LEVEL: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RULE_05
    (sel_r == '0) |-> !run_en_r)
    else $error("run enable set with no level selected");

  AST_RUN_SETS: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RULE_08
    (cmd_evt.run && !cmd_evt.off && sel_r != '0) |=> run_en_r)
    else $error("qualified run did not enable firing");

  AST_OFF_CLEARS: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RULE_07
    (cmd_evt.off && pl_evt == '0) |=> (!run_en_r && $stable(sel_r)))
    else $error("off did not stop firing or altered the level");

  AST_PULSE_HOLD: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RULE_09
    (!run_en_r && sel_r != '0 && qual[12] && !PULSE_N_I) |-> fire_en)
    else $error("held pulse input did not enable firing");

  AST_PULSE_IGNORED: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RULE_10
    (sel_r == '0) |-> !fire_en)
    else $error("firing enabled with no level selected");

  AST_FIRE_ANGLE: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RULE_12
    $fell(TRIAC_FIRE_OUT_N_O) |-> ($past(phase_r) == fire_delay($past(sel_r))
      && $past(fire_en)))
    else $error("firing pulse at the wrong phase or while disabled");

  AST_NARROW_LEN: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RULE_13
    (!WIDE_PULSE && $fell(TRIAC_FIRE_OUT_N_O)) |-> (wcnt_r == NARROW_TICKS_W))
    else $error("firing pulse loaded with the wrong width");

endmodule

//--- tb/acpc_load_model.sv
`timescale 1ns/100ps
module acpc_load_model
  import acpc_pkg::*;
#(
  parameter int HALF = 1440
) (
  input wire logic clk_i,
  input wire logic [9:0] pl_out_n_i,
  input wire logic [9:0] pl_oe_i,
  input wire logic triac_n_i,
  output logic [9:0] pl_in_n_o,
  output logic run_n_o,
  output logic off_n_o,
  output logic pulse_n_o,
  output logic sync_o
);
  logic [9:0] sw_n = 10'h3FF;
  logic triac_q = 1'b1;
  int phase = 0;
  int fire_cnt = 0;
  int last_delay = 0;
  int last_width = 0;
  int low_run = 0;

  initial begin
    run_n_o = 1'b1;
    off_n_o = 1'b1;
    pulse_n_o = 1'b1;
    sync_o = 1'b0;
  end

  // lines have pull-ups, so an undriven line with no switch closed reads high
  assign pl_in_n_o = (pl_oe_i & pl_out_n_i) | (~pl_oe_i & sw_n);

  // ----------------------------------------------------------------
  // line sync and triac observation
  // ----------------------------------------------------------------
  always @(negedge clk_i) begin
    phase <= (phase == HALF - 1) ? 0 : phase + 1;
    if (phase == HALF - 1) sync_o <= ~sync_o;
  end

  always @(posedge clk_i) begin
    triac_q <= triac_n_i;
    if (triac_q && !triac_n_i) begin
      fire_cnt <= fire_cnt + 1;
      last_delay <= phase;
    end
    if (!triac_n_i) begin
      low_run <= low_run + 1;
    end else begin
      if (!triac_q) last_width <= low_run;
      low_run <= 0;
    end
  end

  // ----------------------------------------------------------------
  // switch presses: which bit0 lines, bit1 run, bit2 off, bit3 pulse
  // ----------------------------------------------------------------
  task automatic press(input logic [3:0] which, input logic [9:0] mask, input int clocks);
    @(negedge clk_i);
    if (which[0]) sw_n = ~mask;
    run_n_o = ~which[1];
    off_n_o = ~which[2];
    pulse_n_o = ~which[3];
    repeat (clocks) @(negedge clk_i);
    sw_n = 10'h3FF;
    run_n_o = 1'b1;
    off_n_o = 1'b1;
    pulse_n_o = 1'b1;
  endtask
endmodule

//--- tb/ac_phase_power_control_bench.sv
`timescale 1ns/100ps
module ac_phase_power_control_bench
  import acpc_pkg::*;
;
  // one tick per clock once the loop has measured a 1440-clock half-cycle
  localparam int HALF = 1440;
  localparam int HOLD = HOLD_TICKS + 20;
  localparam int ANGLE [10] = '{78, 86, 93, 100, 107, 112, 119, 127, 137, 149};
  // shortened wide width so the wide build option runs in a short simulation
  localparam int WIDE_SIM = 20;
  logic core_clk, rst, sync, run_n, off_n, pulse_n, triac_n, triac_wide_n;
  logic [9:0] pl_in_n, pl_out_n, pl_oe, msk, exp_lv;
  int n_mismatch = 0;
  int comparisons = 0;
  int seed = 93;
  int k, t;
  int wide_run = 0;
  int wide_width = 0;

  acpc_top u_dut (.CORE_CLK_I(core_clk), .RESET_I(rst), .SYNC_I(sync), .PL_IN_N_I(pl_in_n),
    .PL_OUT_N_O(pl_out_n), .PL_OE_O(pl_oe), .RUN_N_I(run_n), .OFF_N_I(off_n),
    .PULSE_N_I(pulse_n), .TRIAC_FIRE_OUT_N_O(triac_n));
  acpc_load_model #(.HALF(HALF)) u_side (.clk_i(core_clk), .pl_out_n_i(pl_out_n),
    .pl_oe_i(pl_oe), .triac_n_i(triac_n), .pl_in_n_o(pl_in_n), .run_n_o(run_n),
    .off_n_o(off_n), .pulse_n_o(pulse_n), .sync_o(sync));
  // wide build option on the same pins; its level line drive is left open
  acpc_top #(.WIDE_PULSE(1'b1), .WIDE_CYC(WIDE_SIM)) u_dut_wide (.CORE_CLK_I(core_clk),
    .RESET_I(rst), .SYNC_I(sync), .PL_IN_N_I(pl_in_n), .PL_OUT_N_O(), .PL_OE_O(),
    .RUN_N_I(run_n), .OFF_N_I(off_n), .PULSE_N_I(pulse_n), .TRIAC_FIRE_OUT_N_O(triac_wide_n));

  always @(posedge core_clk) begin
    if (triac_wide_n === 1'b0) begin
      wide_run <= wide_run + 1;
    end else begin
      if (wide_run != 0) wide_width <= wide_run;
      wide_run <= 0;
    end
  end

  // ----------------------------------------------------------------
  // compare and helper tasks
  // ----------------------------------------------------------------
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_range(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  task automatic fires(input int n, output int got);
    int start;
    start = u_side.fire_cnt;
    repeat (n * HALF) @(negedge core_clk);
    got = u_side.fire_cnt - start;
  endtask

  function automatic int exp_delay(input int lv);
    return (180 - ANGLE[lv]) * SUB_PER_DEG;
  endfunction

  // waits for the next firing, then checks its phase and width
  task automatic check_fire(input int lv);
    int start;
    int w;
    start = u_side.fire_cnt;
    w = 0;
    while (u_side.fire_cnt == start && w < 2 * HALF) begin
      @(negedge core_clk);
      w++;
    end
    repeat (20) @(negedge core_clk);
    check_range(u_side.last_delay, exp_delay(lv), exp_delay(lv) + 6);
    check_range(u_side.last_width, 5, 7);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    repeat (110_000) @(posedge core_clk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    check_val(32'(pl_oe), 32'h0000);
    check_val(32'(pl_out_n), 32'h03FF);
    // the first half-cycle runs on the preset period, so wait for the first sync edge
    repeat (HALF + 20) @(negedge core_clk);
    // run and pulse held with no level: nothing may fire, not even while pulse is held
    fork
      u_side.press(4'hA, 10'h000, HOLD + HALF + 40);
      begin
        repeat (HOLD + 20) @(negedge core_clk);
        fires(1, k);
        check_range(k, 0, 0);
      end
    join
    u_side.press(4'h1, 10'h008, HOLD / 2);
    check_val(32'(pl_oe), 32'h0000);
    // eight levels keep the run short; both end angles are among them
    for (int i = 0; i < 8; i++) begin
      t = (i * 3 + 1) % 10;
      msk = (10'h001 << t) | (10'($random(seed)) & ~((10'h002 << t) - 10'h001));
      u_side.press(4'h1, msk, HOLD);
      exp_lv = ~(10'h001 << t);
      check_val(32'(pl_oe), 32'(10'h001 << t));
      check_val(32'(pl_out_n), 32'(exp_lv));
      if (i == 0) u_side.press(4'h2, 10'h000, HOLD);
      check_fire(t);
    end
    u_side.press(4'h4, 10'h000, HOLD);
    fires(1, k);
    check_range(k, 0, 0);
    check_val(32'(pl_oe), 32'(10'h001 << t));
    fork
      u_side.press(4'h8, 10'h000, HOLD + 2 * HALF + 100);
      begin
        repeat (HOLD + 20) @(negedge core_clk);
        fires(2, k);
        check_range(k, 2, 2);
      end
    join
    fires(1, k);
    check_range(k, 0, 0);
    u_side.press(4'h2, 10'h000, HOLD);
    check_fire(t);
    check_range(wide_width, WIDE_SIM, WIDE_SIM);
    wrap_up();
  end
endmodule
